//--- kbe_kbc_ctrl.sv
// keyboard-controller emulation control and legacy port enable
// assumes firmware and decoded host cycles arrive as single-cycle strobes on I_CLK_SYS
// Operation
// - aux hardware-set bit makes aux write set flag
// - aux hardware-set off leaves flag to firmware
// - irq enable routes flags to host interrupts
// - source select one uses written host flag
// - source select zero uses output full flag
// - software assist gives firmware the gate
// - otherwise gate follows latest host command or firmware ctrl/aux write
// - aux write clears command flag, sets input full
// - aux data byte is write-only, reads zero
// - host data read returns output byte
// - port enable gates host legacy port writes
// - user control bits are plain storage
// - host config via device one index 30h
// - aux flag set by aux, cleared by data
// - host data read clears full, interrupts firmware
`timescale 1ns/1ps
`include "kbe_defines.svh"
module kbe_kbc_ctrl #(
	parameter logic [15:0] HOST_BASE = 16'h0060
) (
	input  wire logic                   I_CLK_SYS,        // 100 MHz system clock
	input  wire logic                   I_RESET_N,        // system reset, active low
	input  wire logic                   I_PWRGD_CLR,      // power-good reset pulse
	input  wire kbe_pkg::kbe_fw_req_t   I_FW_REQ,         // firmware register access
	output logic [7:0]                  O_FW_RDATA,       // firmware read data
	output logic                        O_FW_RVALID,      // firmware read data valid
	output logic                        O_FW_WR_READY,    // output buffer can take a byte
	input  wire kbe_pkg::kbe_host_req_t I_HOST_REQ,       // decoded host I/O cycle
	input  wire logic                   I_HOST_GATE_VLD,  // host gate command strobe
	input  wire logic                   I_HOST_GATE_VAL,  // host gate command value
	input  wire kbe_pkg::kbe_cfg_req_t  I_CFG_REQ,        // host configuration write
	output logic [7:0]                  O_HOST_RDATA,     // host read data
	output logic                        O_HOST_RVALID,    // host read data valid
	output logic                        O_KBD_IRQ,        // keyboard host interrupt
	output logic                        O_MOUSE_IRQ,      // mouse host interrupt
	output logic                        O_DRAIN_IRQ,      // pulse to firmware on host drain
	output logic                        O_A20_GATE        // address line twenty gate
);
	import kbe_pkg::*;

	typedef struct packed {
		kbe_ctrl_t  ctrl;
		logic [7:0] in_byte;
		logic [7:0] out_byte;
		logic       output_full_flag;
		logic       aux_output_full_flag;
		logic       input_full_flag;
		logic       cmd_flag;
		logic       host_output_flag_value;
		logic       fw_gate;
		logic       gate;
		logic       alt_gate;
		logic       legacy_port_enable_bit;
		logic [7:0] fw_rdata;
		logic       fw_rvalid;
		logic [7:0] host_rdata;
		logic       host_rvalid;
		logic       keyboard_host_irq;
		logic       mouse_host_irq;
		logic       drain_irq;
		logic       a20;
	} kbe_state_t;

	kbe_state_t st_r;
	kbe_state_t st_nxt;
	logic       rst_meta_r;
	logic       rst_n;
	kbe_entry_t push_entry;
	kbe_entry_t head_entry;
	logic       push_valid;
	logic       buf_ready;
	logic       head_valid;
	logic       head_take;
	logic       fw_wr_data;
	logic       fw_wr_aux;
	logic       fw_wr_status;
	logic       fw_wr_ctrl;
	logic       fw_wr_flag;
	logic       fw_rd_aux;
	logic       host_rd_data;
	logic       host_wr_legacy;
	logic       host_output_flag;
	logic [7:0] status_byte;

	// reset asserts at once and releases two edges later
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	assign fw_wr_data     = I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_DATA) && buf_ready;
	assign fw_wr_aux      = I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_AUX) && buf_ready;
	assign fw_wr_status   = I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_STATUS);
	assign fw_wr_ctrl     = I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_CTRL);
	assign fw_wr_flag     = I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_HOST_FLAG);
	assign fw_rd_aux      = I_FW_REQ.rd && (I_FW_REQ.addr == `KBE_OFS_AUX);
	assign host_rd_data   = I_HOST_REQ.rd && (I_HOST_REQ.addr == HOST_BASE + `KBE_HOST_OFS_DATA);
	assign host_wr_legacy = I_HOST_REQ.wr && (I_HOST_REQ.addr == `KBE_HOST_LEGACY);

	// bytes headed to the host queue here; once a slow host drain fills it, further firmware writes are dropped
	assign push_valid = fw_wr_data || fw_wr_aux;
	assign push_entry = '{is_aux: fw_wr_aux, data: I_FW_REQ.wdata};
	assign head_take  = head_valid && !st_r.output_full_flag;

	kbe_pair_buf #(
		.W     ($bits(kbe_entry_t)),
		.DEPTH (2),
		.AW    (1)
	) u_out_buf (
		.clk     (I_CLK_SYS),
		.rst_n   (rst_n),
		.i_valid (push_valid),
		.o_ready (buf_ready),
		.i_data  (push_entry),
		.o_valid (head_valid),
		.i_ready (head_take),
		.o_data  (head_entry)
	);

	assign O_FW_WR_READY = buf_ready;

	// select chooses the written flag or the live full flag
	assign host_output_flag = st_r.ctrl.output_flag_source_select ? st_r.host_output_flag_value
	                                                              : st_r.output_full_flag;

	always_comb begin
		status_byte = '0;
		status_byte[`KBE_ST_OUT_FULL] = st_r.output_full_flag;
		status_byte[`KBE_ST_IN_FULL]  = st_r.input_full_flag;
		status_byte[`KBE_ST_CD]       = st_r.cmd_flag;
		status_byte[`KBE_ST_AUX_FULL] = st_r.aux_output_full_flag;
	end

	always_comb begin
		st_nxt           = st_r;
		st_nxt.fw_rvalid = I_FW_REQ.rd;
		st_nxt.fw_rdata  = '0;
		if (I_FW_REQ.rd) begin
			case (I_FW_REQ.addr)
				`KBE_OFS_DATA:      st_nxt.fw_rdata = st_r.in_byte;
				`KBE_OFS_STATUS:    st_nxt.fw_rdata = status_byte;
				`KBE_OFS_CTRL:      st_nxt.fw_rdata = st_r.ctrl;
				`KBE_OFS_AUX:       st_nxt.fw_rdata = '0;
				`KBE_OFS_HOST_FLAG: st_nxt.fw_rdata = {7'h00, st_r.host_output_flag_value};
				`KBE_OFS_GATE:      st_nxt.fw_rdata = {6'h00, st_r.a20, st_r.fw_gate};
				`KBE_OFS_PORT_EN:   st_nxt.fw_rdata = {7'h00, st_r.legacy_port_enable_bit};
				default:            st_nxt.fw_rdata = '0;
			endcase
		end
		// firmware drains the host byte, clearing input full
		if (I_FW_REQ.rd && (I_FW_REQ.addr == `KBE_OFS_DATA)) begin
			st_nxt.input_full_flag = 1'b0;
		end
		if (fw_wr_ctrl) begin
			st_nxt.ctrl = kbe_ctrl_t'(I_FW_REQ.wdata);
		end
		if (fw_wr_flag) begin
			st_nxt.host_output_flag_value = I_FW_REQ.wdata[0];
		end
		if (I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_GATE)) begin
			st_nxt.fw_gate = I_FW_REQ.wdata[0];
		end
		if (fw_wr_status && !st_r.ctrl.aux_hw_set_enable) begin
			st_nxt.aux_output_full_flag = I_FW_REQ.wdata[`KBE_ST_AUX_FULL];
		end
		if (st_r.ctrl.aux_hw_set_enable) begin
			if (fw_wr_data) begin
				st_nxt.aux_output_full_flag = 1'b0;
			end
			if (fw_wr_aux) begin
				st_nxt.aux_output_full_flag = 1'b1;
			end
		end
		if (fw_wr_aux) begin
			st_nxt.cmd_flag = 1'b0;
		end
		// gate: host command or firmware ctrl or aux write, whichever came last; firmware wins in the same cycle
		if (!st_r.ctrl.software_assist_enable) begin
			if (I_HOST_GATE_VLD) begin
				st_nxt.gate = I_HOST_GATE_VAL;
			end
			if (fw_wr_ctrl || fw_wr_aux) begin
				st_nxt.gate = st_r.fw_gate;
			end
		end

		// host side
		st_nxt.host_rvalid = I_HOST_REQ.rd;
		st_nxt.host_rdata  = '0;
		st_nxt.drain_irq   = 1'b0;
		if (I_HOST_REQ.rd) begin
			if (host_rd_data) begin
				st_nxt.host_rdata = st_r.out_byte;
			end else if (I_HOST_REQ.addr == HOST_BASE + `KBE_HOST_OFS_CMD) begin
				st_nxt.host_rdata = status_byte;
			end
		end
		if (host_rd_data && st_r.output_full_flag) begin
			st_nxt.output_full_flag = 1'b0;
			st_nxt.drain_irq        = 1'b1;
		end
		if (head_take) begin
			st_nxt.out_byte         = head_entry.data;
			st_nxt.output_full_flag = 1'b1;
		end
		if (I_HOST_REQ.wr && (I_HOST_REQ.addr == HOST_BASE + `KBE_HOST_OFS_DATA)) begin
			st_nxt.in_byte  = I_HOST_REQ.wdata;
			st_nxt.cmd_flag = 1'b0;
		end
		if (I_HOST_REQ.wr && (I_HOST_REQ.addr == HOST_BASE + `KBE_HOST_OFS_CMD)) begin
			st_nxt.in_byte  = I_HOST_REQ.wdata;
			st_nxt.cmd_flag = 1'b1;
		end
		// set wins over the firmware drain in the same cycle
		if (fw_wr_aux) begin
			st_nxt.input_full_flag = 1'b1;
		end
		if (I_HOST_REQ.wr && ((I_HOST_REQ.addr == HOST_BASE + `KBE_HOST_OFS_DATA) ||
		                      (I_HOST_REQ.addr == HOST_BASE + `KBE_HOST_OFS_CMD))) begin
			st_nxt.input_full_flag = 1'b1;
		end
		if (host_wr_legacy && st_r.legacy_port_enable_bit) begin
			st_nxt.alt_gate = I_HOST_REQ.wdata[`KBE_LEGACY_ALT_GATE];
		end
		if (I_CFG_REQ.wr && (I_CFG_REQ.logical_device_number == `KBE_CFG_DEV_NUM) &&
		    (I_CFG_REQ.index == `KBE_CFG_IDX_PORT_EN)) begin
			st_nxt.legacy_port_enable_bit = I_CFG_REQ.wdata[0];
		end
		if (I_FW_REQ.wr && (I_FW_REQ.addr == `KBE_OFS_PORT_EN)) begin
			st_nxt.legacy_port_enable_bit = I_FW_REQ.wdata[0];
		end
		if (I_PWRGD_CLR) begin
			st_nxt.legacy_port_enable_bit = 1'b0;
		end

		// outputs, registered; firmware is trusted not to flip the enable while full
		st_nxt.keyboard_host_irq = st_r.ctrl.output_irq_enable && host_output_flag;
		st_nxt.mouse_host_irq    = st_r.ctrl.output_irq_enable && st_r.aux_output_full_flag;
		st_nxt.a20  = (st_r.ctrl.software_assist_enable ? st_r.fw_gate : st_r.gate)
		              || st_r.alt_gate;
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= '0;
			st_r.ctrl <= kbe_ctrl_t'(`KBE_CTRL_RST);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign O_FW_RDATA    = st_r.fw_rdata;
	assign O_FW_RVALID   = st_r.fw_rvalid;
	assign O_HOST_RDATA  = st_r.host_rdata;
	assign O_HOST_RVALID = st_r.host_rvalid;
	assign O_KBD_IRQ     = st_r.keyboard_host_irq;
	assign O_MOUSE_IRQ   = st_r.mouse_host_irq;
	assign O_DRAIN_IRQ   = st_r.drain_irq;
	assign O_A20_GATE    = st_r.a20;

	property p_aux_hw_set;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			fw_wr_aux && st_r.ctrl.aux_hw_set_enable |=> st_r.aux_output_full_flag;
	endproperty
	a_aux_hw_set: assert property (p_aux_hw_set) else $error("aux flag not set by aux write");

	property p_aux_untouched;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			!st_r.ctrl.aux_hw_set_enable && !fw_wr_status |=> $stable(st_r.aux_output_full_flag);
	endproperty
	a_aux_untouched: assert property (p_aux_untouched) else $error("aux flag moved by hardware");

	property p_irq_low;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			!st_r.ctrl.output_irq_enable |=> !O_KBD_IRQ && !O_MOUSE_IRQ;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("host irq high while disabled");

	property p_flag_written;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			fw_wr_flag && st_r.ctrl.output_flag_source_select && !fw_wr_ctrl
			|=> host_output_flag == $past(I_FW_REQ.wdata[0]);
	endproperty
	a_flag_written: assert property (p_flag_written) else $error("host flag not the written value");

	property p_fw_gate;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			st_r.ctrl.software_assist_enable && !st_r.alt_gate |=> O_A20_GATE == $past(st_r.fw_gate);
	endproperty
	a_fw_gate: assert property (p_fw_gate) else $error("gate not under firmware");

	property p_host_gate;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			I_HOST_GATE_VLD && !st_r.ctrl.software_assist_enable && !fw_wr_ctrl && !fw_wr_aux
			|=> st_r.gate == $past(I_HOST_GATE_VAL);
	endproperty
	a_host_gate: assert property (p_host_gate) else $error("host gate command lost");

	property p_aux_status;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			fw_wr_aux |=> st_r.input_full_flag && !st_r.cmd_flag;
	endproperty
	a_aux_status: assert property (p_aux_status) else $error("aux write status wrong");

	property p_aux_reads_zero;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			fw_rd_aux |=> O_FW_RVALID && (O_FW_RDATA == 8'h00);
	endproperty
	a_aux_reads_zero: assert property (p_aux_reads_zero) else $error("aux byte readable");

	property p_host_data;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			host_rd_data |=> O_HOST_RVALID && (O_HOST_RDATA == $past(st_r.out_byte));
	endproperty
	a_host_data: assert property (p_host_data) else $error("host read wrong byte");

	property p_legacy_ignored;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			host_wr_legacy && !st_r.legacy_port_enable_bit |=> $stable(st_r.alt_gate);
	endproperty
	a_legacy_ignored: assert property (p_legacy_ignored) else $error("disabled legacy write taken");

	property p_drain;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			host_rd_data && st_r.output_full_flag && !head_take |=> !st_r.output_full_flag && O_DRAIN_IRQ ##1 !O_DRAIN_IRQ;
	endproperty
	a_drain: assert property (p_drain) else $error("host drain did not clear full");

	property p_pwrgd;
		@(posedge I_CLK_SYS) disable iff (!rst_n)
			I_PWRGD_CLR |=> !st_r.legacy_port_enable_bit;
	endproperty
	a_pwrgd: assert property (p_pwrgd) else $error("enable survived power-good reset");

endmodule : kbe_kbc_ctrl

//--- kbe_defines.svh
// register offsets, field positions, reset values and host decode constants
// for the keyboard-controller emulation control block; definitions only
`ifndef KBE_DEFINES_SVH
`define KBE_DEFINES_SVH

// firmware-side offsets within the block
`define KBE_OFS_DATA        8'h00
`define KBE_OFS_STATUS      8'h04
`define KBE_OFS_CTRL        8'h08
`define KBE_OFS_AUX         8'h0C
`define KBE_OFS_HOST_FLAG   8'h14
`define KBE_OFS_GATE        8'h18
`define KBE_OFS_PORT_EN     8'h30

// host-side decode
`define KBE_HOST_OFS_DATA   16'h0000
`define KBE_HOST_OFS_CMD    16'h0004
`define KBE_HOST_LEGACY     16'h0092
`define KBE_CFG_DEV_NUM     8'h01
`define KBE_CFG_IDX_PORT_EN 8'h30

// status byte and legacy port field positions
`define KBE_ST_OUT_FULL     0
`define KBE_ST_IN_FULL      1
`define KBE_ST_CD           3
`define KBE_ST_AUX_FULL     5
`define KBE_LEGACY_ALT_GATE 1

// reset values
`define KBE_CTRL_RST        8'h00
`define KBE_BYTE_RST        8'h00

`endif

//--- kbe_pkg.sv
// types shared by the keyboard-controller emulation control block
// assumes nothing beyond a SystemVerilog compiler
package kbe_pkg;

	typedef struct packed {
		logic       aux_hw_set_enable;
		logic       user_bit_high;
		logic       output_irq_enable;
		logic [1:0] user_bits_mid;
		logic       output_flag_source_select;
		logic       software_assist_enable;
		logic       user_bit_low;
	} kbe_ctrl_t;

	typedef struct packed {
		logic       is_aux;
		logic [7:0] data;
	} kbe_entry_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kbe_fw_req_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} kbe_host_req_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] logical_device_number;
		logic [7:0] index;
		logic [7:0] wdata;
	} kbe_cfg_req_t;

endpackage : kbe_pkg

//--- kbe_pair_buf.sv
// small ring buffer with valid/ready on both sides
// assumes one clock and a reset already synchronised by the parent
`timescale 1ns/1ps
module kbe_pair_buf #(
	parameter int W     = 9,
	parameter int DEPTH = 2,
	parameter int AW    = 1
) (
	input  wire logic         clk,       // system clock
	input  wire logic         rst_n,     // synchronised reset, active low
	input  wire logic         i_valid,   // fill side offers a word
	output logic              o_ready,   // fill side may push
	input  wire logic [W-1:0] i_data,    // word pushed
	output logic              o_valid,   // drain side has a word
	input  wire logic         i_ready,   // drain side takes the word
	output logic [W-1:0]      o_data     // word at the head
);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    ready;
	} kbe_buf_state_t;

	kbe_buf_state_t st_r;
	kbe_buf_state_t st_nxt;
	logic           push;
	logic           pop;

	assign o_valid = (st_r.cnt != '0);
	assign o_data  = st_r.mem[st_r.rp];
	assign o_ready = st_r.ready;

	always_comb begin
		st_nxt = st_r;
		push   = i_valid && st_r.ready;
		pop    = o_valid && i_ready;
		if (push) begin
			st_nxt.mem[st_r.wp] = i_data;
			st_nxt.wp = (st_r.wp == LAST) ? '0 : st_r.wp + AW'(1);
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == LAST) ? '0 : st_r.rp + AW'(1);
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - (AW+1)'(1);
		end
		// ready is registered so the parent sees a flop, decided from the next count
		st_nxt.ready = (st_nxt.cnt != FULL_CNT);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, ready: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	property p_never_over;
		@(posedge clk) disable iff (!rst_n) st_r.cnt <= FULL_CNT;
	endproperty
	a_never_over: assert property (p_never_over) else $error("buffer count above depth");

	property p_full_stalls;
		@(posedge clk) disable iff (!rst_n) (st_r.cnt == FULL_CNT) |-> !o_ready;
	endproperty
	a_full_stalls: assert property (p_full_stalls) else $error("ready high while full");

endmodule : kbe_pair_buf

//--- kbe_host_model.sv
// host chipset model: decoded I/O reads and writes, configuration writes, gate commands
// assumes one clock shared with the block; requests change just after a rising edge
`timescale 1ns/1ps
module kbe_host_model (
	input  wire logic             clk,       // system clock
	output kbe_pkg::kbe_host_req_t host_req, // decoded I/O cycle
	output kbe_pkg::kbe_cfg_req_t  cfg_req,  // configuration write
	output logic                  gate_vld,  // gate command strobe
	output logic                  gate_val,  // gate command value
	input  wire logic [7:0]       rdata,     // read data from the block
	input  wire logic             rvalid     // read data valid
);
	import kbe_pkg::*;

	initial begin
		host_req = '0;
		cfg_req  = '0;
		gate_vld = 1'b0;
		gate_val = 1'b0;
	end

	// released lines show the inverse of the last value, so a stale byte never passes
	task automatic io(input logic is_wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
		logic ok;
		@(posedge clk);
		host_req <= '{wr: is_wr, rd: !is_wr, addr: a, wdata: d};
		@(posedge clk);
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		ok = is_wr;
		q  = 8'hXX;
		for (int i = 0; i < 3 && !ok; i++) begin
			#1;
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				q  = rdata;
			end else begin
				@(posedge clk);
			end
		end
	endtask : io

	task automatic cfg(input logic [7:0] dev, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		cfg_req <= '{wr: 1'b1, logical_device_number: dev, index: idx, wdata: d};
		@(posedge clk);
		cfg_req <= '{wr: 1'b0, logical_device_number: ~dev, index: ~idx, wdata: ~d};
	endtask : cfg

	task automatic gate(input logic v);
		@(posedge clk);
		gate_vld <= 1'b1;
		gate_val <= v;
		@(posedge clk);
		gate_vld <= 1'b0;
		gate_val <= ~v;
	endtask : gate
endmodule : kbe_host_model

//--- test_kbe_kbc_ctrl.sv
// self-checking bench for the keyboard-controller emulation control block
// assumes the host model file and the design files are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_kbe_kbc_ctrl;
	import kbe_pkg::*;
	localparam logic [15:0] HB = 16'h0060;
	logic          clk;
	logic          rst_n;
	logic          pwrgd;
	kbe_fw_req_t   fw_req;
	kbe_host_req_t host_req;
	kbe_cfg_req_t  cfg_req;
	logic          gate_vld;
	logic          gate_val;
	logic [7:0]    fw_rdata;
	logic          fw_rvalid;
	logic          wr_ready;
	logic [7:0]    h_rdata;
	logic          h_rvalid;
	logic          kbd_irq;
	logic          mouse_irq;
	logic          drain_irq;
	logic          a20;
	int            mismatches;
	int            compares;
	int            pulses;
	int            n;

	kbe_kbc_ctrl #(.HOST_BASE(HB)) i_dut (
		.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PWRGD_CLR(pwrgd), .I_FW_REQ(fw_req),
		.O_FW_RDATA(fw_rdata), .O_FW_RVALID(fw_rvalid), .O_FW_WR_READY(wr_ready),
		.I_HOST_REQ(host_req), .I_HOST_GATE_VLD(gate_vld), .I_HOST_GATE_VAL(gate_val),
		.I_CFG_REQ(cfg_req), .O_HOST_RDATA(h_rdata), .O_HOST_RVALID(h_rvalid),
		.O_KBD_IRQ(kbd_irq), .O_MOUSE_IRQ(mouse_irq), .O_DRAIN_IRQ(drain_irq), .O_A20_GATE(a20));

	kbe_host_model i_host (.clk(clk), .host_req(host_req), .cfg_req(cfg_req), .gate_vld(gate_vld),
		.gate_val(gate_val), .rdata(h_rdata), .rvalid(h_rvalid));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (drain_irq === 1'b1) begin
			pulses++;
		end
	end

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick

	task automatic fw_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		fw_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		fw_req <= '0;
	endtask : fw_wr

	task automatic fw_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
		logic [7:0] q;
		@(posedge clk);
		fw_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		fw_req <= '0;
		q = 8'hXX;
		for (int i = 0; i < 3; i++) begin
			#1;
			if (fw_rvalid === 1'b1) begin
				q = fw_rdata;
				break;
			end
			@(posedge clk);
		end
		`CHK(nm, ex, q)
	endtask : fw_chk

	task automatic host_chk(input logic [15:0] a, input logic [7:0] ex, input string nm);
		logic [7:0] q;
		i_host.io(1'b0, a, 8'h00, q);
		`CHK(nm, ex, q)
	endtask : host_chk

	task automatic host_wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.io(1'b1, a, d, q);
		tick(3);
	endtask : host_wr

	task automatic legacy_wr(input logic [7:0] d);
		host_wr(16'h0092, d);
	endtask : legacy_wr

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	initial begin
		// the whole sequence needs well under 3000 cycles
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		pwrgd = 1'b0;
		fw_req = '0;
		mismatches = 0;
		compares = 0;
		pulses = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		tick(4);
		fw_chk(8'h08, 8'h00, "ctrl reset");
		fw_chk(8'h30, 8'h00, "port enable reset");
		fw_chk(8'h04, 8'h00, "status reset");
		fw_chk(8'h20, 8'h00, "unmapped read");
		fw_wr(8'h08, 8'h59);
		fw_chk(8'h08, 8'h59, "ctrl user bits");
		$display("test reset and storage done");
		// the enable only moves while the output byte is drained
		fw_wr(8'h08, 8'hA0);
		// a host command first, so the aux write has a command flag to clear
		host_wr(HB + 16'h0004, 8'hD1);
		fw_chk(8'h04, 8'h0A, "status after host cmd");
		fw_wr(8'h0C, 8'h5A);
		tick(4);
		fw_chk(8'h04, 8'h23, "status after aux");
		host_chk(HB + 16'h0004, 8'h23, "host status");
		`CHK("mouse irq", 1'b1, mouse_irq)
		`CHK("kbd irq", 1'b1, kbd_irq)
		fw_chk(8'h0C, 8'h00, "aux readback");
		host_chk(HB, 8'h5A, "host aux byte");
		tick(3);
		`CHK("drain pulses", 1, pulses)
		`CHK("kbd irq drained", 1'b0, kbd_irq)
		fw_wr(8'h00, 8'h33);
		tick(4);
		fw_chk(8'h04, 8'h03, "aux flag cleared");
		`CHK("mouse irq off", 1'b0, mouse_irq)
		host_chk(HB, 8'h33, "host data byte");
		fw_chk(8'h00, 8'hD1, "host byte");
		tick(3);
		fw_chk(8'h04, 8'h00, "status drained");
		$display("test aux hardware path done");
		fw_wr(8'h08, 8'h20);
		fw_wr(8'h0C, 8'h77);
		tick(4);
		fw_chk(8'h04, 8'h03, "aux flag untouched");
		fw_wr(8'h04, 8'h20);
		tick(3);
		`CHK("mouse irq fw flag", 1'b1, mouse_irq)
		fw_wr(8'h04, 8'h00);
		host_chk(HB, 8'h77, "host aux byte 2");
		fw_chk(8'h00, 8'hD1, "host byte 2");
		tick(3);
		fw_wr(8'h08, 8'h24);
		fw_wr(8'h14, 8'h01);
		tick(3);
		`CHK("kbd irq host flag", 1'b1, kbd_irq)
		fw_chk(8'h14, 8'h01, "host flag value");
		fw_wr(8'h14, 8'h00);
		tick(3);
		`CHK("kbd irq flag low", 1'b0, kbd_irq)
		fw_wr(8'h08, 8'h04);
		fw_wr(8'h14, 8'h01);
		tick(3);
		`CHK("kbd irq disabled", 1'b0, kbd_irq)
		fw_wr(8'h14, 8'h00);
		$display("test flag sources done");
		fw_wr(8'h08, 8'h00);
		i_host.gate(1'b1);
		tick(3);
		`CHK("a20 host cmd", 1'b1, a20)
		fw_chk(8'h18, 8'h02, "gate register");
		fw_wr(8'h08, 8'h00);
		tick(3);
		`CHK("a20 ctrl write", 1'b0, a20)
		i_host.gate(1'b1);
		fw_wr(8'h0C, 8'h44);
		tick(3);
		`CHK("a20 aux write", 1'b0, a20)
		host_chk(HB, 8'h44, "host aux byte 3");
		fw_chk(8'h00, 8'hD1, "host byte 3");
		fw_wr(8'h08, 8'h02);
		fw_wr(8'h18, 8'h01);
		tick(3);
		`CHK("a20 firmware", 1'b1, a20)
		i_host.gate(1'b0);
		tick(3);
		`CHK("a20 host ignored", 1'b1, a20)
		fw_wr(8'h18, 8'h00);
		tick(3);
		`CHK("a20 firmware low", 1'b0, a20)
		$display("test gate control done");
		legacy_wr(8'h02);
		`CHK("legacy disabled", 1'b0, a20)
		i_host.cfg(8'h01, 8'h30, 8'h01);
		fw_chk(8'h30, 8'h01, "port enable set");
		legacy_wr(8'h02);
		`CHK("legacy enabled", 1'b1, a20)
		i_host.cfg(8'h02, 8'h30, 8'h00);
		fw_chk(8'h30, 8'h01, "wrong device");
		legacy_wr(8'h00);
		`CHK("legacy cleared", 1'b0, a20)
		@(posedge clk);
		pwrgd <= 1'b1;
		@(posedge clk);
		pwrgd <= 1'b0;
		fw_chk(8'h30, 8'h00, "power-good clear");
		legacy_wr(8'h02);
		`CHK("legacy off again", 1'b0, a20)
		$display("test legacy port done");
		fw_wr(8'h08, 8'h00);
		n = 0;
		tick(2);
		while (wr_ready === 1'b1 && n < 4) begin
			fw_wr(8'h00, 8'h10 + 8'(n));
			n++;
			tick(2);
		end
		`CHK("fill count", 3, n)
		fw_wr(8'h00, 8'hEE);
		for (int i = 0; i < n; i++) begin
			host_chk(HB, 8'h10 + 8'(i), "drained byte");
			tick(3);
		end
		fw_chk(8'h04, 8'h00, "buffer empty");
		`CHK("drain pulses total", 7, pulses)
		$display("test buffer done");
		close_out();
	end
endmodule : test_kbe_kbc_ctrl
